// ===== hdl/sec_channel.sv
// Serial absolute encoder channel: registers, trigger, link engine, interrupt
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sec_channel (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        phase_tick_i,
  input  wire logic        servo_tick_i,
  input  wire logic        link_clk_i,
  input  wire logic        link_data_i,
  output logic             link_req_o,
  output logic             link_cmd_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  sec_pkg::sec_ctrl_t  ctrl_q;
  sec_pkg::sec_high_t  high_q;
  sec_pkg::sec_state_t state_q;
  logic [31:0] low_q;
  logic        clk_sel_q;
  logic [1:0]  proto_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic [31:0] rdata_q;
  logic        irq_q;
  logic        req_q;
  logic        cmd_bit_q;
  logic [15:0] cmd_sh_q;
  logic [63:0] rx_sh_q;
  logic [5:0]  crc_q;
  logic [6:0]  cnt_q;
  logic [6:0]  len_q;
  logic [11:0] tmo_q;
  logic        one_pend_q;
  logic        lclk_s1_q;
  logic        lclk_s2_q;
  logic        lclk_s3_q;
  logic        ldat_s1_q;
  logic        ldat_s2_q;

  logic        wr_ctrl;
  logic        tick;
  logic        start;
  logic        rise;
  logic        fall;
  logic        timeout;
  logic        finish;
  logic        crc_bad;
  logic [57:0] pay;
  logic [2:0]  irq_evt;
  logic [5:0]  crc_nx;
  logic [11:0] tmo_lim;

  assign tmo_lim = 12'(sec_pkg::TIMEOUT_CYC);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Two flops per pin; the third clock stage only feeds edge detection
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
      ldat_s1_q <= 1'b0;
      ldat_s2_q <= 1'b0;
    end else begin
      lclk_s1_q <= link_clk_i;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      ldat_s1_q <= link_data_i;
      ldat_s2_q <= ldat_s1_q;
    end
  end

  assign rise = lclk_s2_q & ~lclk_s3_q;
  assign fall = ~lclk_s2_q & lclk_s3_q;

  // ---------------------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------------------
  assign wr_ctrl = reg_wr_i && (reg_addr_i == sec_pkg::OFS_CMD_CTRL);
  assign tick    = clk_sel_q ? servo_tick_i : phase_tick_i;
  // Repeat mode needs a tick; one-shot waits only for idle
  assign start   = (state_q == sec_pkg::ST_IDLE) &&
                   ((!ctrl_q.repeat_one_shot && ctrl_q.arm && tick) ||
                    (ctrl_q.repeat_one_shot && one_pend_q));

  // Frames with a dead link end here rather than hang the channel
  assign timeout = (state_q == sec_pkg::ST_CMD || state_q == sec_pkg::ST_RX) && (tmo_q == tmo_lim);
  assign finish  = (state_q == sec_pkg::ST_FIN) || timeout;

  // Running CRC over payload and appended CRC leaves zero when intact
  always_comb begin
    crc_nx = {crc_q[4:0], 1'b0} ^ ((crc_q[5] ^ ldat_s2_q) ? sec_pkg::CRC_POLY : 6'h00);
  end
  assign crc_bad = (crc_q != 6'h00);
  assign pay     = rx_sh_q[63:6];

  // ---------------------------------------------------------------------------
  // Link engine
  // ---------------------------------------------------------------------------
  // Command goes out on falling link edges, answer is taken on rising edges
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= sec_pkg::ST_IDLE;
      req_q     <= 1'b0;
      cmd_bit_q <= 1'b0;
      cmd_sh_q  <= 16'h0000;
      rx_sh_q   <= 64'h0000_0000_0000_0000;
      crc_q     <= 6'h00;
      cnt_q     <= 7'h00;
      len_q     <= 7'h00;
    end else if (timeout) begin
      // A cut frame must not leave a command bit standing on the line
      state_q   <= sec_pkg::ST_IDLE;
      req_q     <= 1'b0;
      cmd_bit_q <= 1'b0;
    end else begin
      unique case (state_q)
        sec_pkg::ST_IDLE: begin
          if (start) begin
            state_q   <= sec_pkg::ST_CMD;
            req_q     <= 1'b1;
            cmd_bit_q <= ctrl_q.cmd[15];
            cmd_sh_q  <= ctrl_q.cmd;
            rx_sh_q   <= 64'h0000_0000_0000_0000;
            crc_q     <= 6'h00;
            cnt_q     <= 7'h00;
            // Reply length follows protocol and command
            if (proto_q == sec_pkg::PROTO_BISS) begin
              len_q <= sec_pkg::LEN_BISS;
            end else if (proto_q == sec_pkg::PROTO_ENDAT) begin
              len_q <= sec_pkg::LEN_ENDAT;
            end else if (ctrl_q.cmd == sec_pkg::CMD_POS_READ) begin
              len_q <= sec_pkg::LEN_MOTOR_FUL;
            end else begin
              len_q <= sec_pkg::LEN_MOTOR_ST;
            end
          end
        end
        sec_pkg::ST_CMD: begin
          if (fall) begin
            cmd_sh_q  <= {cmd_sh_q[14:0], 1'b0};
            cmd_bit_q <= cmd_sh_q[14];
          end
          if (rise) begin
            if (cnt_q == 7'(sec_pkg::CMD_BITS - 1)) begin
              state_q <= sec_pkg::ST_RX;
              cnt_q   <= 7'h00;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
        end
        sec_pkg::ST_RX: begin
          cmd_bit_q <= 1'b0;
          if (rise) begin
            rx_sh_q <= {rx_sh_q[62:0], ldat_s2_q};
            crc_q   <= crc_nx;
            cnt_q   <= cnt_q + 7'h01;
            if (cnt_q == len_q - 7'h01) begin
              state_q <= sec_pkg::ST_FIN;
            end
          end
        end
        sec_pkg::ST_FIN: begin
          state_q <= sec_pkg::ST_IDLE;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  // Idle time between link edges, cleared on every edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_q <= 12'h000;
    end else if (state_q == sec_pkg::ST_IDLE || rise || fall || timeout) begin
      tmo_q <= 12'h000;
    end else begin
      tmo_q <= tmo_q + 12'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Position data words
  // ---------------------------------------------------------------------------
  // Both words change only at the end of a frame, never from the bus
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_q  <= sec_pkg::RST_ZERO;
      high_q <= sec_pkg::RST_ZERO;
    end else if (timeout) begin
      high_q.timeout <= 1'b1;
      high_q.crc_err <= 1'b0;
    end else if (state_q == sec_pkg::ST_FIN) begin
      high_q.timeout <= 1'b0;
      high_q.crc_err <= crc_bad;
      unique case (proto_q)
        sec_pkg::PROTO_BISS: begin
          low_q          <= pay[37:6];
          high_q.pos_top <= pay[45:38];
          high_q.status  <= pay[5:0];
          high_q.extra   <= 16'h0000;
        end
        sec_pkg::PROTO_ENDAT: begin
          low_q          <= pay[31:0];
          high_q.pos_top <= pay[39:32];
          high_q.status  <= 6'h00;
          high_q.extra   <= 16'h0000;
        end
        default: begin
          // Multi-turn 16, single-turn 23, additional 16, MSB first
          low_q          <= {pay[47:39], pay[38:16]};
          high_q.pos_top <= {1'b0, pay[54:48]};
          high_q.status  <= 6'h00;
          high_q.extra   <= pay[15:0];
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Control and configuration registers
  // ---------------------------------------------------------------------------
  // Command, mode and arm; done is owned by the link engine
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= sec_pkg::RST_CMD_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.cmd             <= reg_wdata_i[31:16];
        ctrl_q.repeat_one_shot <= reg_wdata_i[13];
        ctrl_q.arm             <= reg_wdata_i[12];
      end else if (finish && ctrl_q.repeat_one_shot) begin
        ctrl_q.arm <= 1'b0;
      end
      if (start) begin
        ctrl_q.done <= 1'b0;
      end else if (finish) begin
        ctrl_q.done <= 1'b1;
      end
    end
  end

  // One-shot request: a single frame per write of arm
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      one_pend_q <= 1'b0;
    end else if (wr_ctrl) begin
      one_pend_q <= reg_wdata_i[13] & reg_wdata_i[12];
    end else if (start) begin
      one_pend_q <= 1'b0;
    end
  end

  // Tick source and protocol selection
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_q <= 1'b0;
      proto_q   <= sec_pkg::PROTO_BISS;
    end else if (reg_wr_i && reg_addr_i == sec_pkg::OFS_CLK_SEL) begin
      clk_sel_q <= reg_wdata_i[0];
      proto_q   <= reg_wdata_i[5:4];
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  assign irq_evt[sec_pkg::IRQ_DONE] = finish;
  assign irq_evt[sec_pkg::IRQ_CRC]  = (state_q == sec_pkg::ST_FIN) && crc_bad;
  assign irq_evt[sec_pkg::IRQ_TMO]  = timeout;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == sec_pkg::OFS_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      if (reg_wr_i && reg_addr_i == sec_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= reg_wdata_i[2:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= sec_pkg::RST_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        sec_pkg::OFS_CMD_CTRL: rdata_q <= {ctrl_q.cmd, 2'b00, ctrl_q.repeat_one_shot, ctrl_q.arm,
                                           1'b0, ctrl_q.done, 10'h000};
        sec_pkg::OFS_POS_LOW:  rdata_q <= low_q;
        sec_pkg::OFS_POS_HIGH: rdata_q <= high_q;
        sec_pkg::OFS_CLK_SEL:  rdata_q <= {26'h000_0000, proto_q, 3'h0, clk_sel_q};
        sec_pkg::OFS_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q};
        sec_pkg::OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q};
        default:               rdata_q <= sec_pkg::RST_ZERO;
      endcase
    end else begin
      rdata_q <= sec_pkg::RST_ZERO;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o       = irq_q;
  assign link_req_o  = req_q;
  assign link_cmd_o  = cmd_bit_q;

endmodule

// ===== hdl/sec_pkg.sv
// Constants, register map and carrier types of the serial encoder channel
package sec_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_CTRL  = 8'h00;
  localparam logic [7:0] OFS_POS_LOW   = 8'h04;
  localparam logic [7:0] OFS_POS_HIGH  = 8'h08;
  localparam logic [7:0] OFS_CLK_SEL   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;

  // ---------------------------------------------------------------------------
  // Command codes and protocol selection
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CMD_POS_READ  = 16'h0000;
  localparam logic [15:0] CMD_POS_ERR   = 16'h00D8;
  localparam logic [15:0] CMD_ERR_CLR   = 16'h0040;
  localparam logic [15:0] CMD_MT_CLR    = 16'h0048;
  localparam logic [1:0]  PROTO_BISS    = 2'h0;
  localparam logic [1:0]  PROTO_ENDAT   = 2'h1;
  localparam logic [1:0]  PROTO_MOTOR   = 2'h2;

  // ---------------------------------------------------------------------------
  // Frame lengths in link bits, CRC appended after payload
  // ---------------------------------------------------------------------------
  localparam int          CMD_BITS      = 16;
  localparam int          CRC_BITS      = 6;
  localparam logic [5:0]  CRC_POLY      = 6'h03;
  localparam logic [6:0]  LEN_BISS      = 7'h34;
  localparam logic [6:0]  LEN_ENDAT     = 7'h2E;
  localparam logic [6:0]  LEN_MOTOR_FUL = 7'h3D;
  localparam logic [6:0]  LEN_MOTOR_ST  = 7'h2D;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_MHZ       = 100;
  localparam int          TIMEOUT_US    = 20;
  localparam int          TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;

  // ---------------------------------------------------------------------------
  // Reset values and interrupt bits
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_CMD_CTRL  = 32'h0000_0400;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_CRC       = 1;
  localparam int          IRQ_TMO       = 2;

  // Control register layout
  typedef struct packed {
    logic [15:0] cmd;
    logic [1:0]  rsv_hi;
    logic        repeat_one_shot;
    logic        arm;
    logic        rsv_mid;
    logic        done;
    logic [9:0]  rsv_lo;
  } sec_ctrl_t;

  // BiSS-C style high/status word
  typedef struct packed {
    logic        timeout;
    logic        crc_err;
    logic [5:0]  status;
    logic [15:0] extra;
    logic [7:0]  pos_top;
  } sec_high_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_RX   = 2'b10,
    ST_FIN  = 2'b11
  } sec_state_t;

endpackage

// ===== tb/sec_channel_monitor.sv
// Concurrent checks on the ports of the serial encoder channel
`timescale 1ns/1ps
module sec_channel_monitor (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        phase_tick_i,
  input wire logic        servo_tick_i,
  input wire logic        link_clk_i,
  input wire logic        link_data_i,
  input wire logic        link_req_o,
  input wire logic        link_cmd_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic        one_q;
  logic        arm_q;
  logic        src_q;
  logic [2:0]  mask_q;
  logic [1:0]  frames_q;
  logic [11:0] fcyc_q;
  wire logic   ctrl_wr  = reg_wr_i && reg_addr_i == sec_pkg::OFS_CMD_CTRL;
  wire logic   tick_sel = src_q ? servo_tick_i : phase_tick_i;
  // Shadow of software writes; the hardware arm clear is not mirrored on purpose
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      one_q  <= 1'h0;
      arm_q  <= 1'h0;
      src_q  <= 1'h0;
      mask_q <= 3'h0;
    end else if (reg_wr_i) begin
      if (ctrl_wr) begin
        one_q <= reg_wdata_i[13];
        arm_q <= reg_wdata_i[12];
      end
      if (reg_addr_i == sec_pkg::OFS_CLK_SEL) src_q <= reg_wdata_i[0];
      if (reg_addr_i == sec_pkg::OFS_IRQ_MASK) mask_q <= reg_wdata_i[2:0];
    end
  end
  // Frames since the last control write (saturating) and cycles of the running frame
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frames_q <= 2'h0;
      fcyc_q   <= 12'h0;
    end else begin
      fcyc_q <= link_req_o ? fcyc_q + 12'h1 : 12'h0;
      if (ctrl_wr) frames_q <= 2'h0;
      else if ($rose(link_req_o) && frames_q != 2'h3) frames_q <= frames_q + 2'h1;
    end
  end
  sequence s_busy_read;
    reg_rd_i && reg_addr_i == sec_pkg::OFS_CMD_CTRL && link_req_o ##1 link_req_o;
  endsequence
  sequence s_idle_tick;
    !link_req_o && arm_q && !one_q && !reg_wr_i && tick_sel;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  a_done_busy: assert property (s_busy_read |-> !reg_rdata_o[10])
    else $error("done flag set while a frame runs");
  a_cmd_quiet: assert property (!link_req_o |-> !link_cmd_o)
    else $error("command bit driven outside a frame");
  a_tick_start: assert property (s_idle_tick |=> link_req_o)
    else $error("selected tick did not start a frame");
  a_disarm_idle: assert property (!link_req_o && !arm_q && !reg_wr_i |=> !link_req_o)
    else $error("frame started while disarmed");
  a_shot_start: assert property (ctrl_wr && reg_wdata_i[13:12] == 2'h3 && !link_req_o |=> ##1 link_req_o)
    else $error("one-shot write did not start a frame");
  a_shot_once: assert property (one_q |-> frames_q < 2'h2)
    else $error("one-shot gave more than one frame");
  a_frame_held: assert property ($rose(link_req_o) |-> link_req_o [*8])
    else $error("frame request dropped early");
  a_frame_bound: assert property (fcyc_q < 12'h898)
    else $error("frame not ended by timeout");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_o)
    else $error("interrupt raised while fully masked");
endmodule

bind sec_channel sec_channel_monitor i_sec_channel_monitor (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .phase_tick_i(phase_tick_i), .servo_tick_i(servo_tick_i),
  .link_clk_i(link_clk_i), .link_data_i(link_data_i), .link_req_o(link_req_o),
  .link_cmd_o(link_cmd_o), .irq_o(irq_o));

// ===== tb/sec_encoder_model.sv
// Behavioural absolute encoder on the far side of the serial link
`timescale 1ns/1ps
module sec_encoder_model (
  input  wire logic link_req_i,
  input  wire logic link_cmd_i,
  output logic      link_clk_o,
  output logic      link_data_o
);
  logic [63:0] pl = 64'h0;        // Reply payload, MSB first
  int          plen = 46;
  bit          bad = 1'h0;        // Flip the last CRC bit
  bit          stall = 1'h0;      // Never clock: the channel must time out
  logic [15:0] cmd_seen = 16'h0;
  int          frames = 0;
  logic [5:0]  crc;
  int          j;
  // Clock stands low between frames
  initial begin
    link_clk_o = 1'h0;
    link_data_o = 1'h0;
  end
  // Command taken on rising edges, reply changed on falling edges so it is stable at the rise
  always begin
    @(posedge link_req_i);
    frames++;
    crc = 6'h00;
    #37;
    for (int k = 0; !stall && k < plen + 22; k++) begin
      link_clk_o = 1'h1;
      if (k < 16) cmd_seen = {cmd_seen[14:0], link_cmd_i};
      #80;
      link_clk_o = 1'h0;
      j = k - 15;
      if (j >= 0 && j < plen) begin
        link_data_o = pl[plen - 1 - j];
        crc = {crc[4:0], 1'h0} ^ ((crc[5] ^ link_data_o) ? sec_pkg::CRC_POLY : 6'h00);
      end else if (j >= plen && j < plen + 6) begin
        link_data_o = crc[plen + 5 - j] ^ (bad && j == plen + 5);
      end
      #80;
    end
    wait (!link_req_i);
    link_data_o = ~link_data_o;  // Released line shows no stale value
  end
endmodule

// ===== tb/sec_channel_tb.sv
// Self-checking bench of the serial encoder channel
`timescale 1ns/1ps
module sec_channel_tb;
  logic        core_clk, rst_n, reg_wr, reg_rd, phase_tick, servo_tick;
  logic        link_clk, link_data, link_req, link_cmd, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  int          err_count = 0;
  int          check_count = 0;
  int          f0;

  sec_channel i_sec_channel (.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .phase_tick_i(phase_tick), .servo_tick_i(servo_tick), .link_clk_i(link_clk),
    .link_data_i(link_data), .link_req_o(link_req), .link_cmd_o(link_cmd), .irq_o(irq));
  sec_encoder_model i_sec_encoder_model (.link_req_i(link_req), .link_cmd_i(link_cmd),
    .link_clk_o(link_clk), .link_data_o(link_data));

  // 100 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------------
  // Bus and link helpers
  // --------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded wait; the timeout frame is the longest at about 2000 cycles
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    while (link_req === 1'h1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("frame end", 32'h0, {31'h0, link_req});
    // Encoder still finishes its last link period; a request now would be missed
    repeat (20) @(posedge core_clk);
  endtask
  task automatic tick(input bit s);
    @(posedge core_clk);
    servo_tick <= s;
    phase_tick <= !s;
    @(posedge core_clk);
    servo_tick <= 1'h0;
    phase_tick <= 1'h0;
  endtask
  task automatic shot(input logic [15:0] c, input logic [63:0] p, input int n);
    i_sec_encoder_model.pl = p;
    i_sec_encoder_model.plen = n;
    wr(sec_pkg::OFS_CMD_CTRL, {c, 16'h3000});
    wait_idle();
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_biss;
    sec_pkg::sec_high_t eh;
    eh = '{timeout: 1'h0, crc_err: 1'h0, status: 6'h2D, extra: 16'h0, pos_top: 8'hC3};
    rd(sec_pkg::OFS_CMD_CTRL, v);
    chk("ctrl reset", sec_pkg::RST_CMD_CTRL, v);
    rd(8'h20, v);
    chk("unmapped", 32'h0, v);
    f0 = i_sec_encoder_model.frames;
    shot(sec_pkg::CMD_POS_READ, {18'h0, 40'hC3_8765_4321, 6'h2D}, 46);
    rd(sec_pkg::OFS_CMD_CTRL, v);
    chk("ctrl after shot", 32'h0000_2400, v);
    wr(sec_pkg::OFS_POS_LOW, 32'hFFFF_FFFF);
    wr(sec_pkg::OFS_POS_HIGH, 32'hFFFF_FFFF);
    wr(sec_pkg::OFS_CMD_CTRL, 32'h0000_2000);
    rd(sec_pkg::OFS_CMD_CTRL, v);
    chk("done not writable", 32'h0000_2400, v);
    rd(sec_pkg::OFS_POS_LOW, v);
    chk("low word", 32'h8765_4321, v);
    rd(sec_pkg::OFS_POS_HIGH, v);
    chk("high word", eh, v);
    chk("one frame", f0 + 1, i_sec_encoder_model.frames);
  endtask
  // Bad CRC, then a stalled link; the interrupt is held masked, then raised and cleared
  task automatic t_errs;
    i_sec_encoder_model.bad = 1'h1;
    shot(sec_pkg::CMD_POS_READ, {18'h0, 40'hC3_8765_4321, 6'h2D}, 46);
    i_sec_encoder_model.bad = 1'h0;
    rd(sec_pkg::OFS_POS_HIGH, v);
    chk("crc flag", 32'h1, {30'h0, v[31:30]});
    i_sec_encoder_model.stall = 1'h1;
    shot(sec_pkg::CMD_POS_READ, 64'h0, 46);
    i_sec_encoder_model.stall = 1'h0;
    rd(sec_pkg::OFS_POS_HIGH, v);
    chk("timeout flag", 32'h2, {30'h0, v[31:30]});
    rd(sec_pkg::OFS_POS_LOW, v);
    chk("low kept", 32'h8765_4321, v);
    rd(sec_pkg::OFS_IRQ_STAT, v);
    chk("irq events", 32'h7, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(sec_pkg::OFS_IRQ_MASK, 32'h4);
    @(posedge core_clk);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(sec_pkg::OFS_IRQ_STAT, 32'h7);
    @(posedge core_clk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(sec_pkg::OFS_IRQ_MASK, 32'h0);
  endtask
  // Repeat mode on the servo tick: wrong source and mid-frame ticks start nothing
  task automatic t_repeat;
    wr(sec_pkg::OFS_CLK_SEL, 32'h1);
    wr(sec_pkg::OFS_CMD_CTRL, 32'h0000_1000);
    f0 = i_sec_encoder_model.frames;
    tick(1'h0);
    repeat (4) @(posedge core_clk);
    chk("wrong source", f0, i_sec_encoder_model.frames);
    repeat (2) begin
      tick(1'h1);
      repeat (100) @(posedge core_clk);
      rd(sec_pkg::OFS_CMD_CTRL, v);
      chk("done in frame", 32'h0000_1000, v);
      tick(1'h1);
      wait_idle();
    end
    chk("one per tick", f0 + 2, i_sec_encoder_model.frames);
    wr(sec_pkg::OFS_CMD_CTRL, 32'h0);
    tick(1'h1);
    wait_idle();
    chk("disarmed", f0 + 2, i_sec_encoder_model.frames);
  endtask
  task automatic t_protocols;
    logic [15:0] c;
    wr(sec_pkg::OFS_CLK_SEL, 32'h10);
    shot(sec_pkg::CMD_POS_READ, {24'h0, 40'h12_3456_789A}, 40);
    rd(sec_pkg::OFS_POS_LOW, v);
    chk("second protocol low", 32'h3456_789A, v);
    wr(sec_pkg::OFS_CLK_SEL, 32'h20);
    shot(sec_pkg::CMD_POS_READ, {9'h0, 16'hBEEF, 23'h5A_5A5A, 16'h1357}, 55);
    rd(sec_pkg::OFS_POS_LOW, v);
    chk("motor low", {9'h0EF, 23'h5A_5A5A}, v);
    rd(sec_pkg::OFS_POS_HIGH, v);
    chk("motor high", {8'h0, 16'h1357, 8'h5F}, v);
    chk("read cmd", 32'h0, {16'h0, i_sec_encoder_model.cmd_seen});
    shot(sec_pkg::CMD_POS_ERR, {25'h0, 23'h1A_BCDE, 16'h0F0F}, 39);
    rd(sec_pkg::OFS_POS_LOW, v);
    chk("single turn", 32'h1A_BCDE, {9'h0, v[22:0]});
    rd(sec_pkg::OFS_POS_HIGH, v);
    chk("error code", 32'h000F_0F00, {8'h0, v[23:0]});
    chk("error cmd", 32'hD8, {16'h0, i_sec_encoder_model.cmd_seen});
    f0 = i_sec_encoder_model.frames;
    for (int i = 0; i < 16; i++) begin
      c = i < 8 ? sec_pkg::CMD_ERR_CLR : sec_pkg::CMD_MT_CLR;
      shot(c, 64'h0, 39);
      chk("clear cmd", {16'h0, c}, {16'h0, i_sec_encoder_model.cmd_seen});
    end
    chk("clear count", f0 + 16, i_sec_encoder_model.frames);
  endtask
  task automatic results;
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    phase_tick = 1'h0;
    servo_tick = 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    t_biss();
    t_errs();
    t_repeat();
    t_protocols();
    results();
  end
  // About 25 frames of up to 1.3k cycles each, one timeout frame of about 2k; 0.8 ms leaves ample margin
  initial begin
    #800000;
    err_count++;
    results();
  end
endmodule
